//--- dv/sequential_multiplier_divider_tb_top.sv
// bench top for smd_top: register access, divide, multiply, abort.
// assumes smd_pkg, smd_top and smd_chk are compiled first.
`timescale 1ns/10ps
`default_nettype none
module sequential_multiplier_divider_tb_top;
    import smd_pkg::*;
    logic         core_clk   = 1'b0;
    logic         reset_n    = 1'b0;
    smd_apb_req_t apbReq     = '0;
    smd_apb_rsp_t apbRsp;
    logic         arithDoneIrq;
    int           err_total  = 0;
    int           n_compared = 0;
    int           irqCount   = 0;
    int           n0;
    logic [31:0]  rd;
    logic         er;
    logic [31:0]  q;
    logic [31:0]  dvd [3]    = '{32'hFFFF_FFFF, 32'h1234_5678, 32'h0000_0005};
    logic [15:0]  dvs [3]    = '{16'hFFFF, 16'h0123, 16'h0007};
    smd_top uut (.core_clk(core_clk), .reset_n(reset_n), .apbReq(apbReq), .apbRsp(apbRsp),
                 .arithDoneIrq(arithDoneIrq));
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) if (arithDoneIrq === 1'b1) irqCount <= irqCount + 1;
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd, input logic [3:0] sb);
        int i;
        @(posedge core_clk);
        apbReq.psel    <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.pwrite  <= wr;
        apbReq.paddr   <= ADDR_W'({idx, 2'b00});
        apbReq.pwdata  <= wd;
        apbReq.pstrb   <= sb;
        @(posedge core_clk);
        apbReq.penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge core_clk);
            if (apbRsp.pready === 1'b1) break;
        end
        if (i == 16) begin
            err_total++;
            finish_test();
        end
        rd = apbRsp.prdata;
        er = apbRsp.pslverr;
        apbReq.psel    <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d, 4'hF);
    endtask
    task automatic rdc(input string nm, input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0, 4'h0);
        chk(nm, rd, exp);
    endtask
    task automatic wait_irq(input int n);
        int i;
        for (i = 0; i < 60 && irqCount == n; i++) @(posedge core_clk);
        chk("irq", irqCount, n + 1);
    endtask
    initial begin
        #500000;
        err_total++;
        finish_test();
    end
    initial begin
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        rdc("rem", IDX_REMAINDER_RESULT, 32'h0);
        rdc("alo", IDX_OPERAND_A_LOW, 32'h0);
        rdc("ahi", IDX_OPERAND_A_HIGH, 32'h0);
        rdc("opb", IDX_OPERAND_B, 32'h0);
        rdc("ctl", IDX_ARITH_CONTROL, 32'h0);
        apb(1'b0, 16'h0100, 32'h0, 4'h0);
        chk("err", {31'h0, er}, 32'h1);
        wr(IDX_ARITH_CONTROL, 32'h7E);
        rdc("ctl", IDX_ARITH_CONTROL, 32'h0);
        apb(1'b1, IDX_OPERAND_B, 32'h0000_5634, 4'h1);
        apb(1'b1, IDX_OPERAND_B, 32'h0000_AB00, 4'h2);
        rdc("opb", IDX_OPERAND_B, 32'h0000_AB34);
        $display("test registers done");
        for (int k = 0; k < 3; k++) begin
            wr(IDX_OPERAND_A_LOW, {16'h0, dvd[k][15:0]});
            wr(IDX_OPERAND_A_HIGH, {16'h0, dvd[k][31:16]});
            wr(IDX_OPERAND_B, {16'h0, dvs[k]});
            n0 = irqCount;
            wr(IDX_ARITH_CONTROL, 32'h80);
            wait_irq(n0);
            q = dvd[k] / dvs[k];
            rdc("qlo", IDX_OPERAND_A_LOW, {16'h0, q[15:0]});
            rdc("qhi", IDX_OPERAND_A_HIGH, {16'h0, q[31:16]});
            q = dvd[k] % dvs[k];
            rdc("rem", IDX_REMAINDER_RESULT, q);
            rdc("ctl", IDX_ARITH_CONTROL, 32'h0);
        end
        $display("test divide done");
        wr(IDX_OPERAND_A_LOW, 32'h0000_FFFF);
        wr(IDX_OPERAND_A_HIGH, 32'h0000_1234);
        wr(IDX_OPERAND_B, 32'h0000_FFFF);
        n0 = irqCount;
        wr(IDX_ARITH_CONTROL, 32'h81);
        wait_irq(n0);
        rdc("plo", IDX_OPERAND_A_LOW, 32'h0000_0001);
        rdc("phi", IDX_OPERAND_A_HIGH, 32'h0000_FFFE);
        rdc("rem", IDX_REMAINDER_RESULT, 32'h0);
        rdc("ctl", IDX_ARITH_CONTROL, 32'h1);
        $display("test multiply done");
        n0 = irqCount;
        wr(IDX_ARITH_CONTROL, 32'h80);
        repeat (5) @(posedge core_clk);
        wr(IDX_ARITH_CONTROL, 32'h0);
        repeat (40) @(posedge core_clk);
        chk("irq", irqCount, n0);
        rdc("ctl", IDX_ARITH_CONTROL, 32'h0);
        $display("test abort done");
        wr(IDX_OPERAND_A_LOW, 32'h0000_0003);
        wr(IDX_OPERAND_B, 32'h0000_0005);
        n0 = irqCount;
        wr(IDX_ARITH_CONTROL, 32'h81);
        repeat (13) @(posedge core_clk);
        wr(IDX_ARITH_CONTROL, 32'h0);
        wait_irq(n0);
        rdc("plo", IDX_OPERAND_A_LOW, 32'h0000_000F);
        rdc("phi", IDX_OPERAND_A_HIGH, 32'h0);
        $display("test late clear done");
        finish_test();
    end
endmodule
bind smd_top smd_chk chk_i (.core_clk(core_clk), .reset_n(reset_n), .apbReq(apbReq), .apbRsp(apbRsp),
                            .arithDoneIrq(arithDoneIrq));
`default_nettype wire

//--- dv/smd_chk.sv
// checker: port-level assertions for smd_top.
// assumes one clock domain and a bind from the bench top.
`timescale 1ns/10ps
`default_nettype none
module smd_chk (
    input wire logic                  core_clk,
    input wire logic                  reset_n,
    input wire smd_pkg::smd_apb_req_t apbReq,
    input wire smd_pkg::smd_apb_rsp_t apbRsp,
    input wire logic                  arithDoneIrq
);
    import smd_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic ctrlWr;
    logic startMul;
    logic startDiv;
    assign ctrlWr   = apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite && apbReq.pstrb[0]
                      && apbReq.paddr == ADDR_W'({IDX_ARITH_CONTROL, 2'b00});
    assign startMul = ctrlWr && apbReq.pwdata[7:0] == 8'h81;
    assign startDiv = ctrlWr && apbReq.pwdata[7] && !apbReq.pwdata[0];
    // edges since start, and whether a clearing write came before the last step
    logic [5:0] opCnt;
    logic       opMul;
    logic       opAbort;
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            opCnt   <= 6'h00;
            opMul   <= 1'b0;
            opAbort <= 1'b0;
        end else if (startMul || startDiv) begin
            opCnt   <= 6'h01;
            opMul   <= startMul;
            opAbort <= 1'b0;
        end else begin
            if (opCnt != 6'h00 && opCnt != 6'h3F) begin
                opCnt <= opCnt + 6'h01;
            end
            if (ctrlWr && !apbReq.pwdata[7] && opCnt != 6'h00
                && opCnt < (opMul ? 6'(MUL_CYCLES) : 6'(DIV_CYCLES))) begin
                opAbort <= 1'b1;
            end
        end
    end
    setup_ready_a: assert property (apbReq.psel && !apbReq.penable |=> apbRsp.pready)
        else $error("no ready after setup");
    ready_access_a: assert property (apbRsp.pready |-> apbReq.psel && apbReq.penable)
        else $error("ready outside access phase");
    ready_pulse_a: assert property (apbRsp.pready |=> !apbRsp.pready)
        else $error("ready longer than one cycle");
    rdata_idle_a: assert property (!apbRsp.pready |-> apbRsp.prdata == '0)
        else $error("read data without ready");
    err_ready_a: assert property (apbRsp.pslverr |-> apbRsp.pready)
        else $error("error without ready");
    irq_pulse_a: assert property (arithDoneIrq |=> !arithDoneIrq)
        else $error("done pulse too long");
    reset_quiet_a: assert property (disable iff (1'b0) !reset_n |=> !apbRsp.pready && !arithDoneIrq)
        else $error("outputs active in reset");
    mul_time_a: assert property (startMul |-> ##1 !arithDoneIrq[*8] ##11 (arithDoneIrq || opAbort))
        else $error("multiply done at wrong cycle");
    div_time_a: assert property (startDiv |-> ##1 !arithDoneIrq[*8] ##27 (arithDoneIrq || opAbort))
        else $error("divide done at wrong cycle");
    cover property (startMul);
    cover property (startDiv);
    cover property (apbRsp.pslverr);
endmodule
`default_nettype wire

//--- logic/smd_top.sv
// sequential 16x16 multiplier and 32/16 divider with apb register access.
// assumes apb master follows setup/access phasing; single clock, sync reset.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// RL1 - remainder holds zero after multiply, division remainder after divide
// RL2 - reset clears remainder, both operand a halves and operand b
// RL3 - reset clears control register: stopped, division mode
// RL4 - setting start clears the remainder at operation start
// RL5 - starting a multiplication clears operand a upper half
// RL6 - control bit 0 selects division (0) or multiplication (1)
// RL7 - control bit 7 starts; hardware clears it when finished
// RL8 - multiply operand a low by operand b into all of operand a
// RL9 - divide operand a by operand b: quotient to a, remainder separately
// RL10 - multiplication completes after exactly 16 clock cycles
// RL11 - division completes after exactly 32 clock cycles
// RL12 - operand a takes partial results every cycle while running
// RL13 - results stored first, then start bit cleared, then interrupt
// RL14 - clearing start while running aborts; results invalid
// RL15 - completion coinciding with clearing write keeps result and interrupt
// RL16 - software must not change operands or mode while running
// RL17 - software must not divide by a zero divisor
// RL18 - after abort software reloads operands and control before restarting
// RL19 - to multiply load a low and b, then write control 81h
// RL20 - to divide load a and b, then write control with start only
// RL21 - operands and remainder allow byte or halfword access; control bytewise
// RL22 - control bits 6 to 1 read zero and ignore writes
// RL23 - completion interrupt is one clock pulse per finished operation
module smd_top (
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    input  wire smd_pkg::smd_apb_req_t apbReq,
    output var  smd_pkg::smd_apb_rsp_t apbRsp,
    output logic                       arithDoneIrq
);
    import smd_pkg::*;

    function automatic logic regHit(input logic [ADDR_W-1:0] addr, input logic [IDX_W-1:0] idx);
        regHit = (addr == {2'b00, idx, 2'b00});
    endfunction

    function automatic logic [15:0] mergeHalf(input logic [15:0] old, input logic [15:0] wdata,
                                              input logic [1:0] strb);
        mergeHalf = {strb[1] ? wdata[15:8] : old[15:8], strb[0] ? wdata[7:0] : old[7:0]};
    endfunction

    smd_state_t        stateReg;
    smd_state_t        stateNext;
    smd_apb_rsp_t      rspReg;
    logic [15:0]       remainderReg;
    logic [15:0]       operandALowReg;
    logic [15:0]       operandAHighReg;
    logic [15:0]       operandBReg;
    logic              startReg;
    logic              modeReg;
    logic              irqReg;
    logic              finishSeenReg;
    logic [CNT_W-1:0]  cntReg;

    logic              setupPhase;
    logic              busWrite;
    logic              wrCtrl;
    logic              startCmd;
    logic              clearCmd;
    logic              running;
    logic              lastStep;
    logic              launch;
    logic              abortOp;
    logic              wrALow;
    logic              wrAHigh;
    logic              wrB;
    logic [31:0]       operandA;
    logic [16:0]       mulSum;
    logic [16:0]       divTrial;
    logic              divFits;
    logic [16:0]       divDiff;
    logic [31:0]       readData;
    logic              readHit;

    assign setupPhase = apbReq.psel & ~apbReq.penable;
    assign busWrite   = apbReq.psel & apbReq.penable & apbReq.pwrite & rspReg.pready;
    assign wrCtrl     = busWrite & regHit(apbReq.paddr, IDX_ARITH_CONTROL) & apbReq.pstrb[0];
    assign wrALow     = busWrite & regHit(apbReq.paddr, IDX_OPERAND_A_LOW);
    assign wrAHigh    = busWrite & regHit(apbReq.paddr, IDX_OPERAND_A_HIGH);
    assign wrB        = busWrite & regHit(apbReq.paddr, IDX_OPERAND_B);
    assign startCmd   = wrCtrl & apbReq.pwdata[CTRL_START_BIT];
    assign clearCmd   = wrCtrl & ~apbReq.pwdata[CTRL_START_BIT];
    assign running    = (stateReg == SMD_RUN);
    assign lastStep   = (cntReg == (modeReg ? MUL_LAST : DIV_LAST)); // see RL10 see RL11
    assign launch     = startCmd & ~running;                         // see RL7
    assign abortOp    = running & clearCmd & ~lastStep;              // see RL14 see RL15
    assign operandA   = {operandAHighReg, operandALowReg};

    // multiply step: add b to upper half when lsb set, then shift right
    assign mulSum     = {1'b0, operandAHighReg} + (operandALowReg[0] ? {1'b0, operandBReg} : 17'h00000);
    // divide step: shift dividend msb into remainder, subtract when it fits
    assign divTrial   = {remainderReg, operandAHighReg[15]};
    assign divDiff    = divTrial - {1'b0, operandBReg};
    assign divFits    = (divTrial >= {1'b0, operandBReg});

    // operation sequencer
    always_comb begin
        stateNext = stateReg;
        unique case (stateReg)
            SMD_IDLE: begin
                if (launch) begin
                    stateNext = SMD_RUN;
                end
            end
            SMD_RUN: begin
                if (abortOp) begin
                    stateNext = SMD_IDLE;                            // see RL14
                end else if (lastStep) begin
                    stateNext = SMD_FINISH;                          // see RL13
                end
            end
            SMD_FINISH: begin
                stateNext = launch ? SMD_RUN : SMD_IDLE;
            end
            default: begin
                stateNext = SMD_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            stateReg <= SMD_IDLE;
        end else begin
            stateReg <= stateNext;
        end
    end

    // start bit mirrors the running state, cleared one cycle after results
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            startReg <= RESET_CTRL[CTRL_START_BIT];                  // see RL3
        end else begin
            startReg <= (stateNext != SMD_IDLE);                     // see RL7 see RL13
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            modeReg <= RESET_MODE;                                   // see RL3
        end else if (wrCtrl) begin
            modeReg <= apbReq.pwdata[CTRL_MODE_BIT];                 // see RL6 see RL21
        end
    end

    // completion pulse follows the cycle that clears the start bit
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            finishSeenReg <= 1'b0;
        end else begin
            finishSeenReg <= (stateReg == SMD_FINISH);               // see RL13
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            irqReg <= 1'b0;
        end else begin
            irqReg <= finishSeenReg;                                 // see RL13 see RL23 see RL15
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cntReg <= '0;
        end else if (launch) begin
            cntReg <= '0;
        end else if (running) begin
            cntReg <= cntReg + CNT_W'(1);
        end
    end

    // operand a: launch clearing, bus writes, then iteration
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            operandAHighReg <= RESET_HALF;                           // see RL2
            operandALowReg  <= RESET_HALF;
        end else if (launch) begin
            if (apbReq.pwdata[CTRL_MODE_BIT]) begin
                operandAHighReg <= RESET_HALF;                       // see RL5
            end
        end else if (wrALow || wrAHigh) begin
            if (wrALow) begin
                operandALowReg <= mergeHalf(operandALowReg, apbReq.pwdata[15:0], apbReq.pstrb[1:0]); // see RL21
            end
            if (wrAHigh) begin
                operandAHighReg <= mergeHalf(operandAHighReg, apbReq.pwdata[15:0], apbReq.pstrb[1:0]);
            end
        end else if (running) begin
            if (modeReg) begin
                {operandAHighReg, operandALowReg} <= {mulSum, operandALowReg[15:1]};           // see RL8 see RL12
            end else begin
                {operandAHighReg, operandALowReg} <= {operandA[30:0], divFits};               // see RL9 see RL12
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            operandBReg <= RESET_HALF;                               // see RL2
        end else if (wrB) begin
            operandBReg <= mergeHalf(operandBReg, apbReq.pwdata[15:0], apbReq.pstrb[1:0]); // see RL21
        end
    end

    // remainder stays zero in multiply mode, tracks partial remainder in divide
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            remainderReg <= RESET_HALF;                              // see RL2
        end else if (launch) begin
            remainderReg <= RESET_HALF;                              // see RL4
        end else if (running && !modeReg) begin
            remainderReg <= divFits ? divDiff[15:0] : divTrial[15:0]; // see RL1 see RL9
        end
    end

    // read mux
    always_comb begin
        readData = 32'h00000000;
        readHit  = 1'b1;
        if (regHit(apbReq.paddr, IDX_REMAINDER_RESULT)) begin
            readData = {16'h0000, remainderReg};
        end else if (regHit(apbReq.paddr, IDX_OPERAND_A_LOW)) begin
            readData = {16'h0000, operandALowReg};
        end else if (regHit(apbReq.paddr, IDX_OPERAND_A_HIGH)) begin
            readData = {16'h0000, operandAHighReg};
        end else if (regHit(apbReq.paddr, IDX_OPERAND_B)) begin
            readData = {16'h0000, operandBReg};
        end else if (regHit(apbReq.paddr, IDX_ARITH_CONTROL)) begin
            readData = {24'h000000, startReg, 6'b000000, modeReg};   // see RL22
        end else begin
            readHit = 1'b0;
        end
    end

    // apb answer: one wait-free access cycle after setup, all from flops
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rspReg <= '0;
        end else begin
            rspReg.pready  <= setupPhase;
            rspReg.prdata  <= (setupPhase && !apbReq.pwrite) ? readData : 32'h00000000;
            rspReg.pslverr <= setupPhase & ~readHit;
        end
    end

    assign apbRsp       = rspReg;
    assign arithDoneIrq = irqReg;

endmodule
`default_nettype wire

//--- shared/smd_pkg.sv
// package of the sequential multiplier/divider: register map, field layout,
// reset values, timing counts, state encoding and bus carrier types.
// assumes a 32-bit apb slave port with byte strobes and a 20-bit byte address.
`default_nettype none
package smd_pkg;

    localparam int unsigned ADDR_W   = 20;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned STRB_W   = 4;
    localparam int unsigned IDX_W    = 16;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_REMAINDER_RESULT = 16'hFF60;
    localparam logic [IDX_W-1:0] IDX_OPERAND_A_LOW    = 16'hFF62;
    localparam logic [IDX_W-1:0] IDX_OPERAND_A_HIGH   = 16'hFF64;
    localparam logic [IDX_W-1:0] IDX_OPERAND_B        = 16'hFF66;
    localparam logic [IDX_W-1:0] IDX_ARITH_CONTROL    = 16'hFF68;

    // arith_control fields
    localparam int unsigned CTRL_START_BIT = 7;
    localparam int unsigned CTRL_MODE_BIT  = 0;

    // reset values
    localparam logic [15:0] RESET_HALF = 16'h0000;
    localparam logic [7:0]  RESET_CTRL = 8'h00;
    localparam logic        RESET_MODE = 1'b0;

    // operation lengths in peripheral clock cycles
    localparam int unsigned MUL_CYCLES = 16;
    localparam int unsigned DIV_CYCLES = 32;
    localparam int unsigned CNT_W      = 5;
    localparam logic [CNT_W-1:0] MUL_LAST = CNT_W'(MUL_CYCLES - 1);
    localparam logic [CNT_W-1:0] DIV_LAST = CNT_W'(DIV_CYCLES - 1);

    typedef enum logic [2:0] {
        SMD_IDLE   = 3'b001,
        SMD_RUN    = 3'b010,
        SMD_FINISH = 3'b100
    } smd_state_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
        logic [STRB_W-1:0] pstrb;
    } smd_apb_req_t;

    typedef struct packed {
        logic              pready;
        logic [DATA_W-1:0] prdata;
        logic              pslverr;
    } smd_apb_rsp_t;

endpackage
`default_nettype wire
